// ==== logic/ebt_regs.vh ====
`ifndef EBT_REGS_VH
`define EBT_REGS_VH
// register word offsets (wishbone word addresses)
`define EBT_OFF_COUNT      4'h0
`define EBT_OFF_LIMIT      4'h1
`define EBT_OFF_CONTROL    4'h2
`define EBT_OFF_STATUS     4'h3
`define EBT_OFF_MASK       4'h4
// control field positions
`define EBT_PRE_LO         0
`define EBT_PRE_HI         1
`define EBT_RUN_BIT        2
`define EBT_POST_LO        3
`define EBT_POST_HI        6
`define EBT_CTRL_WMASK     7'h7F
// reset values
`define EBT_COUNT_RST      8'h00
`define EBT_LIMIT_RST      8'hFF
`define EBT_CONTROL_RST    7'h00
// prescaler codes and terminal counts
`define EBT_PRE_DIV1       2'b00
`define EBT_PRE_DIV4       2'b01
`define EBT_PRE_TC4        4'h3
`define EBT_PRE_TC16       4'hF
`endif

// ==== logic/ebt_prescaler.v ====
`timescale 1ns/1ns
`include "ebt_regs.vh"
module ebt_prescaler (
  input  wire       clk_sys_i,
  input  wire       reset_n_i,
  input  wire       clear_i,
  input  wire       run_i,
  input  wire [1:0] select_i,
  output wire       tick_o
);
  reg  [3:0] div_r;
  reg  [3:0] div_nxt;
  wire [3:0] term;

  // codes 10 and 11 both give divide by sixteen
  assign term   = (select_i == `EBT_PRE_DIV1) ? 4'h0 :
                  (select_i == `EBT_PRE_DIV4) ? `EBT_PRE_TC4 : `EBT_PRE_TC16;
  assign tick_o = run_i && (div_r >= term);

  always @* begin
    div_nxt = div_r;
    if (clear_i) begin
      div_nxt = 4'h0;
    end else if (run_i) begin
      div_nxt = tick_o ? 4'h0 : div_r + 4'h1;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_nxt;
    end
  end
endmodule // ebt_prescaler

// ==== logic/ebt_postscaler.v ====
`timescale 1ns/1ns
`include "ebt_regs.vh"
module ebt_postscaler (
  input  wire       clk_sys_i,
  input  wire       reset_n_i,
  input  wire       clear_i,
  input  wire       match_i,
  input  wire [3:0] select_i,
  output wire       event_o
);
  reg  [3:0] cnt_r;
  reg  [3:0] cnt_nxt;

  assign event_o = match_i && !clear_i && (cnt_r >= select_i);

  always @* begin
    cnt_nxt = cnt_r;
    if (clear_i) begin
      cnt_nxt = 4'h0;
    end else if (match_i) begin
      cnt_nxt = event_o ? 4'h0 : cnt_r + 4'h1;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // ebt_postscaler

// ==== logic/ebt_timer.v ====
`timescale 1ns/1ns
`include "ebt_regs.vh"
// Behaviour
// - period_count is an eight-bit up counter holding the timer value.
// - period_limit is an eight-bit value compared with period_count on every count.
// - software can read and write period_count, period_limit and timer_control.
// - pre_divide_select (bits 1-0) divides the clock by one, four or sixteen.
// - post_divide_select (bits 6-3) divides match events by its value plus one.
// - an interrupt request comes from the postscaled match (status bit 0) or the raw match (status bit 1), as enabled by the mask.
// - timer_run (bit 2) enables counting; cleared, the timer stops.
// - a write to period_count clears both the prescaler and the postscaler.
// - a write to timer_control clears both the prescaler and the postscaler.
// - any device reset clears the prescaler and postscaler counters.
// - a write to timer_control leaves period_count unchanged.
// - the match output is offered as a time base for the pwm channels.
module ebt_timer (
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  output wire        irq_o,
  output reg         time_base_o
);
  reg  [7:0]  count_r;
  reg  [7:0]  count_nxt;
  reg  [7:0]  limit_r;
  reg  [6:0]  control_r;
  reg  [1:0]  status_r;
  reg  [1:0]  status_nxt;
  reg  [1:0]  mask_r;
  reg  [31:0] rdata;
  reg         mapped;

  wire        req;
  wire        wr;
  wire        wr_count;
  wire        wr_control;
  wire        tick;
  wire        match;
  wire        post_event;
  wire        div_clear;

  // one access per request; ack in the cycle after stb, then dropped
  assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr         = req && wb_we_i && wb_sel_i[0];
  assign wr_count   = wr && (wb_adr_i == `EBT_OFF_COUNT);
  assign wr_control = wr && (wb_adr_i == `EBT_OFF_CONTROL);
  assign div_clear  = wr_count || wr_control;

  ebt_prescaler u_pre (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .clear_i   (div_clear),
    .run_i     (control_r[`EBT_RUN_BIT]),
    .select_i  (control_r[`EBT_PRE_HI:`EBT_PRE_LO]),
    .tick_o    (tick)
  );

  assign match = tick && (count_r == limit_r);

  ebt_postscaler u_post (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .clear_i   (div_clear),
    .match_i   (match),
    .select_i  (control_r[`EBT_POST_HI:`EBT_POST_LO]),
    .event_o   (post_event)
  );

  // count: software write wins over counting in the same cycle
  always @* begin
    count_nxt = count_r;
    if (wr_count) begin
      count_nxt = wb_dat_i[7:0];
    end else if (match) begin
      count_nxt = 8'h00;
    end else if (tick) begin
      count_nxt = count_r + 8'h01;
    end
  end

  // bit 0 postscaled interrupt, bit 1 raw match; set beats write-one-clear
  always @* begin
    status_nxt = status_r;
    if (req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `EBT_OFF_STATUS)) begin
      status_nxt = status_r & ~wb_dat_i[1:0];
    end
    if (post_event) begin
      status_nxt[0] = 1'b1;
    end
    if (match) begin
      status_nxt[1] = 1'b1;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r     <= `EBT_COUNT_RST;
      limit_r     <= `EBT_LIMIT_RST;
      control_r   <= `EBT_CONTROL_RST;
      status_r    <= 2'b00;
      mask_r      <= 2'b00;
      time_base_o <= 1'b0;
    end else begin
      count_r     <= count_nxt;
      status_r    <= status_nxt;
      time_base_o <= match;
      if (wr && (wb_adr_i == `EBT_OFF_LIMIT)) begin
        limit_r <= wb_dat_i[7:0];
      end
      if (wr_control) begin
        control_r <= wb_dat_i[6:0] & `EBT_CTRL_WMASK;
      end
      if (wr && (wb_adr_i == `EBT_OFF_MASK)) begin
        mask_r <= wb_dat_i[1:0];
      end
    end
  end

  assign irq_o = |(status_r & mask_r);

  always @* begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    case (wb_adr_i)
      `EBT_OFF_COUNT:   rdata[7:0] = count_r;
      `EBT_OFF_LIMIT:   rdata[7:0] = limit_r;
      `EBT_OFF_CONTROL: rdata[6:0] = control_r;
      `EBT_OFF_STATUS:  rdata[1:0] = status_r;
      `EBT_OFF_MASK:    rdata[1:0] = mask_r;
      default:          mapped     = 1'b0;
    endcase
  end

  // unmapped addresses answer with err instead of ack
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && !wb_we_i) ? rdata : 32'h0000_0000;
    end
  end
endmodule // ebt_timer

// ==== tb/ebt_timer_sva.sv ====
`timescale 1ns/1ns
module ebt_timer_sva (
  input wire        clk_sys_i,
  input wire        reset_n_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  input wire        irq_o,
  input wire        time_base_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  AST_MAP_ACK: assert property (s_req ##0 wb_adr_i < 4'h5 |=> wb_ack_o && !wb_err_o) else $error("no ack");
  AST_BAD_ERR: assert property (s_req ##0 wb_adr_i > 4'h4 |=> wb_err_o && !wb_ack_o) else $error("no err");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ERR_ONE: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data not idle");
  AST_DAT_WIDTH: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper bits");
  AST_NOT_BOTH: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
  // sticky flag: only a register write may drop the request
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_we_i)) else $error("irq dropped");
endmodule // ebt_timer_sva
bind ebt_timer ebt_timer_sva u_sva (.*);

// ==== tb/ebt_timer_tb_top.sv ====
`timescale 1ns/1ns
module ebt_timer_tb_top;
  reg         clk_sys_i = 0;
  reg         reset_n_i = 0;
  reg         cyc = 0;
  reg         we = 0;
  reg  [3:0]  adr = 4'h0;
  reg  [31:0] wdat = 32'h0000_0000;
  reg  [31:0] rd;
  wire [31:0] dat_o;
  wire        ack, err, irq_o, time_base_o;
  integer     errors = 0, n_checks = 0, seed = 41524, cyc_n = 0, i, n, lim, p;
  ebt_timer uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
    .irq_o(irq_o), .time_base_o(time_base_o));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  function integer div_of(input integer c);
    div_of = c == 0 ? 1 : c == 1 ? 4 : 16;
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      if (errors == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // no fixed latency assumed: the global timeout ends a stuck wait
  task wb(input w, input [3:0] a, input [31:0] d);
    begin
      {cyc, we, adr, wdat} <= {1'b1, w, a, d};
      @(posedge clk_sys_i);
      while (!(ack | err)) @(posedge clk_sys_i);
      rd = dat_o;
      cyc <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask
  task rc(input [3:0] a, input [31:0] exp);
    begin
      wb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
    end
  endtask
  task gap(output integer g);
    begin
      @(posedge clk_sys_i iff time_base_o);
      g = 0;
      do begin
        @(posedge clk_sys_i);
        g = g + 1;
      end while (!time_base_o);
    end
  endtask
  always @(posedge clk_sys_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      errors = errors + 1;
      summarize;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rc(0, 0);
    rc(1, 32'h0000_00FF);
    for (i = 2; i < 8; i = i + 1) rc(i, 0);
    for (i = 0; i < 4; i = i + 1) begin
      n = $random(seed);
      wb(1'b1, 1, n);
      wb(1'b1, 2, n & 32'h0000_007B);
      wb(1'b1, 0, n);
      wb(1'b1, 4'h9, ~n);
      rc(1, n & 255);
      rc(2, n & 32'h0000_007B);
      rc(0, n & 255);
    end
    lim = 2 + ($random(seed) & 7);
    wb(1'b1, 1, lim);
    for (p = 0; p < 4; p = p + 1) begin
      wb(1'b1, 2, 4 + p);
      gap(n);
      chk(n, (lim + 1) * div_of(p));
    end
    for (i = 0; i < 3; i = i + 1) begin
      p = i == 0 ? 15 : $random(seed) & 15;
      wb(1'b1, 2, 0);
      wb(1'b1, 3, 3);
      wb(1'b1, 4, 1);
      chk(irq_o, 0);
      wb(1'b1, 0, 0);
      wb(1'b1, 2, p * 8 + 4);
      n = 0;
      do begin
        @(posedge clk_sys_i);
        n = n + time_base_o;
      end while (!irq_o);
      chk(n, p + 1);
      wb(1'b1, 2, 0);
      wb(0, 0, 0);
      n = rd;
      wb(1'b1, 2, 32'h0000_0078);
      rc(0, n);
      chk(irq_o, 1);
      wb(1'b1, 4, 0);
      chk(irq_o, 0);
    end
    summarize;
  end
endmodule // ebt_timer_tb_top
